// file: verilog/dpc_pkg.sv
// Purpose: shared constants and types for the phy controller port
// Assumes: half-rate interface, one strobe group, 8-bit memory data
// Notes:   widths fixed; timing counts derived from the clock rate
package dpc_pkg;
  localparam int          RATE_WIDTH_RATIO = 4;
  localparam int          MEM_DWIDTH       = 8;
  localparam int          DQS_GROUPS       = 1;
  localparam int          CS_WIDTH         = 2;
  localparam int          CLK_PAIRS        = 2;
  localparam int          DLL_WIDTH        = 6;
  localparam int          DBG_AW           = 3;
  localparam int          HALF_W           = DQS_GROUPS * RATE_WIDTH_RATIO / 2;
  localparam int          CTL_DW           = MEM_DWIDTH * RATE_WIDTH_RATIO;
  localparam int          MASK_W           = RATE_WIDTH_RATIO;
  localparam int          WLAT_W           = 5;
  localparam int          RLAT_W           = 5;
  localparam int          PH_MAX           = 16;
  localparam int          PH_W             = 5;
  localparam int          FIFO_DEPTH       = 16;
  localparam int          CLK_MHZ          = 25;
  localparam int          SETTLE_NS        = 200;
  localparam int          SETTLE_CYC       = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int          SCAN_DIV         = 8;
  localparam logic [4:0]  PH_STEPS_360     = 5'h08;
  localparam logic [4:0]  PH_STEPS_720     = 5'h10;
  localparam logic [4:0]  WLAT_DEFAULT     = 5'h02;
  localparam logic [4:0]  RLAT_BASE        = 5'h0F;
  localparam logic [31:0] DBG_SCRATCH_RST  = 32'h0000_0000;
  localparam logic [DBG_AW-1:0] DBG_STATUS  = 3'h0;
  localparam logic [DBG_AW-1:0] DBG_PHASE   = 3'h1;
  localparam logic [DBG_AW-1:0] DBG_LAT     = 3'h2;
  localparam logic [DBG_AW-1:0] DBG_PASSMAP = 3'h3;
  localparam logic [DBG_AW-1:0] DBG_SCRATCH = 3'h4;

  typedef struct packed {
    logic [CTL_DW-1:0] data;
    logic [MASK_W-1:0] mask;
  } dpc_wr_word_s;

  typedef enum logic [2:0] {
    CAL_IDLE, CAL_SET, CAL_SAMPLE, CAL_ANALYZE, CAL_PASS, CAL_FAIL
  } dpc_cal_state_e;
endpackage

// file: verilog/dpc_fifo.sv
// Purpose: write-data buffer between controller and memory pins
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty are exact; no write while full
`timescale 1ns/1ps
`default_nettype none
module dpc_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/dpc_phy_port.sv
// Purpose: controller-facing side of a ddr3 phy with calibration sweep
// Assumes: clk is the full-rate clock; ctl side runs on a half-rate enable
// Notes:   memory-side word pins carry a whole half-rate word per beat
`timescale 1ns/1ps
`default_nettype none
// Function
// [RQ1] supply half-rate controller clock and a reset synchronous to it
// [RQ2] scan reset drops asynchronously, releases on scan clock after global reset
// [RQ3] strobe-burst drives memory strobe; controller raises it before write valid
// [RQ4] write-data-valid makes the data and mask output enables; here both enables go all-ones when a buffered word leaves the fifo
// [RQ5] 5-bit write latency, valid after successful calibration, then constant
// [RQ6] write latency lies between 0 and 31 controller cycles
// [RQ7] controller asserts doing-read one cycle per read, with the command
// [RQ8] doing-read enables capture registers and makes read-data-valid
// [RQ9] read-data-valid is two bits, one per half-cycle of half-rate clock
// [RQ10] read latency counts cycles from doing-read to valid read data
// [RQ11] clock-disable bit stops driving that memory clock pair, both legs
// [RQ12] success flag set on passing calibration, failure flag on failing
// [RQ13] recalibration request and group select are accepted and ignored
// [RQ14] sweep resync phase over 360 or 720 degrees, centre the pass window
// [RQ15] window size is the count of passing phase positions
// [RQ16] read latency reported for chosen phase; meaningless on failure
// [RQ17] no passing phase fails calibration and sets no-window error
// [RQ18] more than one pass window fails calibration, sets multi-window error
// [RQ19] ratio 2 is full rate, 4 half rate; buses scale by it
// [RQ20] calibration uses only the first chip select
// [RQ21] debug port: select, read, write, 32-bit data, wait request
// [RQ22] export own strobe delay word; import another's instead of own loop
// [RQ23] active-low global reset clears all phy logic, level sensitive
// [RQ24] controller waits write latency after chip select before write valid
// [RQ25] success and failure never both set; both hold until reset
module dpc_phy_port
  import dpc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 global_reset_n,
  output logic                      ctl_clk,
  output logic                      ctl_reset_n,
  output logic                      aux_half_rate_clk,
  output logic                      aux_full_rate_clk,
  output logic                      aux_scan_clk,
  output logic                      aux_scan_clk_reset_n,
  input  wire logic [HALF_W-1:0]    ctl_dqs_burst,
  input  wire logic [HALF_W-1:0]    ctl_wdata_valid,
  input  wire logic [CTL_DW-1:0]    ctl_wdata,
  input  wire logic [MASK_W-1:0]    write_byte_mask,
  output logic                      ctl_wdata_ready,
  output logic [WLAT_W-1:0]         ctl_wlat,
  input  wire logic [HALF_W-1:0]    ctl_doing_rd,
  output logic [CTL_DW-1:0]         ctl_rdata,
  output logic [HALF_W-1:0]         ctl_rdata_valid,
  output logic [RLAT_W-1:0]         ctl_rlat,
  input  wire logic [CS_WIDTH*2-1:0] ctl_cs_n,
  input  wire logic [CLK_PAIRS-1:0] ctl_mem_clk_disable,
  output logic                      ctl_cal_success,
  output logic                      ctl_cal_fail,
  input  wire logic                 ctl_cal_req,
  input  wire logic [CS_WIDTH-1:0]  ctl_cal_byte_lane_sel_n,
  input  wire logic                 sweep_720,
  output logic [PH_W-1:0]           resync_phase,
  input  wire logic                 cal_read_ok,
  output logic [PH_W-1:0]           rsu_codvw_phase,
  output logic [PH_W-1:0]           rsu_codvw_size,
  output logic [RLAT_W-1:0]         rsu_read_latency,
  output logic                      rsu_no_dvw_err,
  output logic                      rsu_grt_one_dvw_err,
  input  wire logic [DLL_WIDTH-1:0] dll_code_local,
  input  wire logic                 dll_use_import,
  input  wire logic [DLL_WIDTH-1:0] dqs_delay_ctrl_import,
  output logic [DLL_WIDTH-1:0]      dqs_delay_ctrl_export,
  output logic [DLL_WIDTH-1:0]      dqs_delay_ctrl,
  input  wire logic [DBG_AW-1:0]    dbg_addr,
  input  wire logic                 dbg_cs,
  input  wire logic                 dbg_rd,
  input  wire logic                 dbg_wr,
  input  wire logic [31:0]          dbg_wr_data,
  output logic [31:0]               dbg_rd_data,
  output logic                      dbg_waitrequest,
  output logic [CS_WIDTH*2-1:0]     mem_cs_n,
  output logic [CLK_PAIRS-1:0]      mem_clk_o,
  output logic [CLK_PAIRS-1:0]      mem_clk_n_o,
  output logic [CLK_PAIRS-1:0]      mem_clk_oe,
  output logic [CTL_DW-1:0]         mem_dq_o,
  output logic [HALF_W-1:0]         mem_dq_oe,
  output logic [MASK_W-1:0]         mem_dm_o,
  output logic [HALF_W-1:0]         mem_dm_oe,
  output logic [HALF_W-1:0]         mem_dqs_oe,
  input  wire logic [CTL_DW-1:0]    mem_dq_i,
  input  wire logic                 mem_wr_ready
);
  logic                grst_meta_reg, grst_sync_reg;
  logic                ok_meta_reg, ok_sync_reg;
  logic                wrdy_meta_reg, wrdy_sync_reg;
  logic [CTL_DW-1:0]   dq_meta_reg, dq_sync_reg;
  logic                rst;
  logic                half_reg;
  logic                ctl_en;
  logic [2:0]          scan_cnt_reg;
  logic                scan_clk_reg;
  logic                scan_en;
  logic                scan_rst_reg;
  logic                ctl_rst_n_reg;
  dpc_cal_state_e      cal_state_reg;
  logic [PH_W-1:0]     phase_reg;
  logic [3:0]          settle_reg;
  logic [PH_MAX-1:0]   pass_map_reg;
  logic [PH_W-1:0]     steps;
  logic [PH_W-1:0]     win_first;
  logic [PH_W-1:0]     win_size;
  logic [PH_W-1:0]     win_count;
  logic                cal_busy;
  logic [HALF_W-1:0]   rd_pipe_reg [32];
  dpc_wr_word_s        fifo_in;
  dpc_wr_word_s        fifo_out;
  logic                fifo_out_valid;
  logic                fifo_pop;
  logic [31:0]         scratch_reg;
  logic                dbg_rd_done_reg;

  // pins from outside pass two flops first
  always_ff @(posedge clk) begin
    grst_meta_reg <= global_reset_n;
    grst_sync_reg <= grst_meta_reg;
    ok_meta_reg   <= cal_read_ok;
    ok_sync_reg   <= ok_meta_reg;
    wrdy_meta_reg <= mem_wr_ready;
    wrdy_sync_reg <= wrdy_meta_reg;
    dq_meta_reg   <= mem_dq_i;
    dq_sync_reg   <= dq_meta_reg;
  end

  assign rst = sys_rst || !grst_sync_reg; // RQ23

  // half-rate clock and its enable
  always_ff @(posedge clk) begin
    if (rst) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= !half_reg;
    end
  end
  assign ctl_en            = half_reg;
  assign ctl_clk           = half_reg; // RQ1
  assign aux_half_rate_clk = half_reg;
  assign aux_full_rate_clk = clk;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_rst_n_reg <= 1'b0;
    end else if (ctl_en) begin
      ctl_rst_n_reg <= 1'b1; // RQ1
    end
  end
  assign ctl_reset_n = ctl_rst_n_reg;

  // scan clock divider
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_cnt_reg <= '0;
      scan_clk_reg <= 1'b0;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 3'h1;
      if (scan_cnt_reg == 3'(SCAN_DIV - 1)) begin
        scan_clk_reg <= !scan_clk_reg;
      end
    end
  end
  assign scan_en      = (scan_cnt_reg == 3'(SCAN_DIV - 1)) && !scan_clk_reg;
  assign aux_scan_clk = scan_clk_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      scan_rst_reg <= 1'b0;
    end else if (scan_en) begin
      scan_rst_reg <= 1'b1; // RQ2
    end
  end
  // raw pin gate gives asynchronous assertion without waiting for a clock
  assign aux_scan_clk_reset_n = scan_rst_reg && global_reset_n; // RQ2

  // calibration sweep
  assign steps    = sweep_720 ? PH_STEPS_720 : PH_STEPS_360; // RQ14
  assign cal_busy = (cal_state_reg != CAL_PASS) && (cal_state_reg != CAL_FAIL);

  always_ff @(posedge clk) begin
    if (rst) begin
      cal_state_reg <= CAL_IDLE;
      phase_reg     <= '0;
      settle_reg    <= '0;
      pass_map_reg  <= '0;
    end else if (ctl_en) begin
      case (cal_state_reg)
        CAL_IDLE: begin
          phase_reg     <= '0;
          settle_reg    <= 4'(SETTLE_CYC);
          cal_state_reg <= CAL_SET;
        end
        CAL_SET: begin
          if (settle_reg == 4'h0) begin
            cal_state_reg <= CAL_SAMPLE;
          end else begin
            settle_reg <= settle_reg - 4'h1;
          end
        end
        CAL_SAMPLE: begin
          pass_map_reg[phase_reg[3:0]] <= ok_sync_reg; // RQ14
          settle_reg <= 4'(SETTLE_CYC);
          if (phase_reg == steps - 5'h01) begin
            cal_state_reg <= CAL_ANALYZE;
          end else begin
            phase_reg     <= phase_reg + 5'h01;
            cal_state_reg <= CAL_SET;
          end
        end
        CAL_ANALYZE: begin
          if (win_count == 5'h01) begin
            cal_state_reg <= CAL_PASS;
          end else begin
            cal_state_reg <= CAL_FAIL; // RQ17 RQ18
          end
        end
        default: begin
          // recalibration request is unsupported; result holds until reset
          cal_state_reg <= cal_state_reg; // RQ13 RQ25
        end
      endcase
    end
  end
  assign resync_phase = cal_busy ? phase_reg : rsu_codvw_phase;

  // window search; no wrap-around, so a window split at the sweep end counts twice
  always_comb begin
    win_count = '0;
    win_size  = '0;
    win_first = '0;
    for (int i = 0; i < PH_MAX; i++) begin
      if (5'(i) < steps && pass_map_reg[i]) begin
        win_size = win_size + 5'h01; // RQ15
        if (i == 0 || !pass_map_reg[i-1]) begin
          win_count = win_count + 5'h01; // RQ18
          if (win_count == 5'h01) begin
            win_first = 5'(i);
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rsu_codvw_phase     <= '0;
      rsu_codvw_size      <= '0;
      rsu_read_latency    <= '0;
      rsu_no_dvw_err      <= 1'b0;
      rsu_grt_one_dvw_err <= 1'b0;
      ctl_cal_success     <= 1'b0;
      ctl_cal_fail        <= 1'b0;
      ctl_wlat            <= '0;
    end else if (ctl_en && cal_state_reg == CAL_ANALYZE) begin
      rsu_codvw_phase     <= win_first + (win_size >> 1); // RQ14
      rsu_codvw_size      <= win_size; // RQ15
      rsu_read_latency    <= RLAT_BASE + 5'(win_first + (win_size >> 1) >= (steps >> 1)); // RQ16
      rsu_no_dvw_err      <= (win_count == 5'h00); // RQ17
      rsu_grt_one_dvw_err <= (win_count > 5'h01); // RQ18
      ctl_cal_success     <= (win_count == 5'h01); // RQ12 RQ25
      ctl_cal_fail        <= (win_count != 5'h01); // RQ12 RQ25
      if (win_count == 5'h01) begin
        ctl_wlat <= WLAT_DEFAULT; // RQ5 RQ6
      end
    end
  end
  assign ctl_rlat = rsu_read_latency; // RQ10

  // only the first chip select is exercised while calibrating
  assign mem_cs_n = cal_busy ? {{(CS_WIDTH*2-2){1'b1}}, 2'b10} : ctl_cs_n; // RQ20

  // memory clock pairs
  generate
    for (genvar p = 0; p < CLK_PAIRS; p++) begin : g_clk
      assign mem_clk_o[p]   = half_reg;
      assign mem_clk_n_o[p] = !half_reg;
      assign mem_clk_oe[p]  = !ctl_mem_clk_disable[p]; // RQ11
    end
  endgenerate

  // write path; the fifo absorbs stalls from the pin side
  assign fifo_in.data = ctl_wdata;
  assign fifo_in.mask = write_byte_mask; // RQ19
  assign fifo_pop     = ctl_en && wrdy_sync_reg;

  dpc_fifo #(
    .WIDTH ($bits(dpc_wr_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (ctl_en && (ctl_wdata_valid != '0)),
    .in_ready  (ctl_wdata_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_dq_o   <= '0;
      mem_dm_o   <= '0;
      mem_dq_oe  <= '0;
      mem_dm_oe  <= '0;
      mem_dqs_oe <= '0;
    end else if (ctl_en) begin
      mem_dqs_oe <= ctl_dqs_burst; // RQ3
      if (fifo_pop && fifo_out_valid) begin
        mem_dq_o  <= fifo_out.data;
        mem_dm_o  <= fifo_out.mask;
        mem_dq_oe <= {HALF_W{1'b1}}; // RQ4
        mem_dm_oe <= {HALF_W{1'b1}}; // RQ4
      end else begin
        mem_dq_oe <= '0;
        mem_dm_oe <= '0;
      end
    end
  end

  // read path: doing-read delayed by the reported latency
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        rd_pipe_reg[i] <= '0;
      end
    end else if (ctl_en) begin
      rd_pipe_reg[0] <= ctl_doing_rd; // RQ8 RQ7
      for (int i = 1; i < 32; i++) begin
        rd_pipe_reg[i] <= rd_pipe_reg[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_rdata_valid <= '0;
      ctl_rdata       <= '0;
    end else if (ctl_en) begin
      ctl_rdata_valid <= rd_pipe_reg[rsu_read_latency - 5'h01]; // RQ9 RQ10
      if (rd_pipe_reg[rsu_read_latency - 5'h01] != '0) begin
        ctl_rdata <= dq_sync_reg; // RQ8
      end
    end
  end

  // strobe delay word sharing
  always_ff @(posedge clk) begin
    if (rst) begin
      dqs_delay_ctrl_export <= '0;
      dqs_delay_ctrl        <= '0;
    end else begin
      dqs_delay_ctrl_export <= dll_code_local; // RQ22
      dqs_delay_ctrl        <= dll_use_import ? dqs_delay_ctrl_import : dll_code_local; // RQ22
    end
  end

  // debug port, one wait cycle per read
  assign dbg_waitrequest = dbg_cs && dbg_rd && !dbg_rd_done_reg; // RQ21

  always_ff @(posedge clk) begin
    if (rst) begin
      dbg_rd_done_reg <= 1'b0;
      dbg_rd_data     <= '0;
      scratch_reg     <= DBG_SCRATCH_RST;
    end else begin
      dbg_rd_done_reg <= dbg_waitrequest;
      if (dbg_cs && dbg_wr && dbg_addr == DBG_SCRATCH) begin
        scratch_reg <= dbg_wr_data; // RQ21
      end
      if (dbg_waitrequest) begin
        if (dbg_addr == DBG_STATUS) begin
          dbg_rd_data <= {27'h0, cal_busy, rsu_grt_one_dvw_err, rsu_no_dvw_err,
                          ctl_cal_fail, ctl_cal_success};
        end else if (dbg_addr == DBG_PHASE) begin
          dbg_rd_data <= {19'h0, rsu_codvw_size, 3'h0, rsu_codvw_phase};
        end else if (dbg_addr == DBG_LAT) begin
          dbg_rd_data <= {19'h0, ctl_wlat, 3'h0, rsu_read_latency};
        end else if (dbg_addr == DBG_PASSMAP) begin
          dbg_rd_data <= {16'h0, pass_map_reg};
        end else if (dbg_addr == DBG_SCRATCH) begin
          dbg_rd_data <= scratch_reg;
        end else begin
          dbg_rd_data <= '0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/dpc_phy_chk.sv
// Purpose: port checker for the phy controller port
// Assumes: one clock, sys_rst synchronous and active high
// Notes:   global reset also disables, its synchroniser lags the pin
`timescale 1ns/1ps
`default_nettype none
module dpc_phy_chk
  import dpc_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              global_reset_n,
  input wire logic              aux_scan_clk_reset_n,
  input wire logic              ctl_cal_success,
  input wire logic              ctl_cal_fail,
  input wire logic [WLAT_W-1:0] ctl_wlat,
  input wire logic              rsu_no_dvw_err,
  input wire logic              rsu_grt_one_dvw_err,
  input wire logic [1:0]        ctl_mem_clk_disable,
  input wire logic [1:0]        mem_clk_oe,
  input wire logic [3:0]        mem_cs_n,
  input wire logic [3:0]        ctl_cs_n,
  input wire logic [1:0]        ctl_rdata_valid,
  input wire logic              dbg_cs,
  input wire logic              dbg_rd,
  input wire logic              dbg_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !global_reset_n);
  flags_excl_a: assert property (!(ctl_cal_success && ctl_cal_fail))
    else $error("success and failure flags both high");
  succ_hold_a: assert property (ctl_cal_success |=> ctl_cal_success)
    else $error("success flag dropped");
  fail_hold_a: assert property (ctl_cal_fail |=> ctl_cal_fail)
    else $error("failure flag dropped");
  wlat_val_a: assert property (ctl_wlat == (ctl_cal_success ? WLAT_DEFAULT : 5'h00))
    else $error("write latency wrong for calibration state");
  clk_oe_a: assert property (mem_clk_oe == ~ctl_mem_clk_disable)
    else $error("memory clock enable does not follow disable");
  no_win_a: assert property (rsu_no_dvw_err |-> ctl_cal_fail && !ctl_cal_success)
    else $error("no-window error without failure");
  multi_win_a: assert property (rsu_grt_one_dvw_err |-> ctl_cal_fail)
    else $error("multi-window error without failure");
  cal_cs_a: assert property (mem_cs_n == ((ctl_cal_success || ctl_cal_fail) ? ctl_cs_n : 4'hE))
    else $error("chip select wrong for calibration state");
  rd_valid_a: assert property (ctl_rdata_valid != 2'h0 |-> ctl_cal_success)
    else $error("read valid before calibration passed");
  dbg_wait_a: assert property (dbg_cs && dbg_rd && dbg_waitrequest |=> !dbg_waitrequest)
    else $error("debug read waited more than one cycle");
  scan_rst_a: assert property (disable iff (1'b0) !global_reset_n |-> !aux_scan_clk_reset_n)
    else $error("scan reset high during global reset");
  pass_c: cover property ($rose(ctl_cal_success));
  fail_c: cover property ($rose(ctl_cal_fail));
  read_c: cover property (ctl_rdata_valid == 2'h3);
endmodule
bind dpc_phy_port dpc_phy_chk u_chk (.*);
`default_nettype wire

// file: verification/dpc_mem_model.sv
// Purpose: memory-pin side stand-in for calibration and data
// Assumes: pass map says which resync phases read back correctly
// Notes:   write-ready stalls on command so the buffer can fill
`timescale 1ns/1ps
`default_nettype none
module dpc_mem_model
  import dpc_pkg::*;
(
  input  wire logic [PH_W-1:0]   resync_phase,
  input  wire logic [15:0]       pass_map,
  input  wire logic [CTL_DW-1:0] rd_word,
  input  wire logic              wr_ok,
  output logic                   cal_read_ok,
  output logic [CTL_DW-1:0]      mem_dq_i,
  output logic                   mem_wr_ready
);
  assign cal_read_ok = pass_map[resync_phase[3:0]];
  assign mem_dq_i = rd_word;
  assign mem_wr_ready = wr_ok;
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: self-checking bench for the phy controller port
// Assumes: bench plays the controller, model plays the memory pins
// Notes:   calibration reruns only after reset, so each map costs one
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dpc_pkg::*;
;
  logic clk, sys_rst, global_reset_n, ctl_clk, ctl_reset_n, aux_half_rate_clk;
  logic aux_full_rate_clk, aux_scan_clk, aux_scan_clk_reset_n, ctl_wdata_ready;
  logic ctl_cal_success, ctl_cal_fail, ctl_cal_req, sweep_720, cal_read_ok;
  logic rsu_no_dvw_err, rsu_grt_one_dvw_err, dll_use_import, mem_wr_ready, wr_ok;
  logic dbg_cs, dbg_rd, dbg_wr, dbg_waitrequest, pre_en, pre_rdy;
  logic [1:0] ctl_dqs_burst, ctl_wdata_valid, ctl_doing_rd, ctl_rdata_valid, mem_dq_oe;
  logic [1:0] mem_dm_oe, mem_dqs_oe, ctl_mem_clk_disable, ctl_cal_byte_lane_sel_n;
  logic [1:0] mem_clk_o, mem_clk_n_o, mem_clk_oe;
  logic [31:0] ctl_wdata, ctl_rdata, mem_dq_o, mem_dq_i, rd_word, dbg_wr_data, dbg_rd_data, rd_q;
  logic [3:0] write_byte_mask, mem_dm_o, ctl_cs_n, mem_cs_n;
  logic [4:0] ctl_wlat, ctl_rlat, resync_phase, rsu_codvw_phase, rsu_codvw_size, rsu_read_latency;
  logic [4:0] e_rlat;
  logic [5:0] dll_code_local, dqs_delay_ctrl_import, dqs_delay_ctrl_export, dqs_delay_ctrl;
  logic [2:0] dbg_addr;
  logic [15:0] pass_map;
  logic [35:0] wq[$];
  int fails, n_compared;

  dpc_phy_port dut (.*);
  dpc_mem_model u_mem (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // enable and ready seen before the edge, free of update races
  always @(negedge clk) begin
    pre_en = ctl_clk;
    pre_rdy = ctl_wdata_ready;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic next_en();
    do @(posedge clk); while (pre_en !== 1'b1);
  endtask
  // {none, multi, size, phase, rlat}; windows never wrap
  function automatic logic [16:0] exp_cal(input logic [15:0] map, input int st);
    int first, cnt, wins;
    logic [4:0] ph;
    first = -1;
    cnt = 0;
    wins = 0;
    for (int i = 0; i < st; i++) begin
      if (map[i]) begin
        cnt++;
        if (first < 0) first = i;
        if (i == 0 || !map[i-1]) wins++;
      end
    end
    ph = 5'(first + cnt / 2);
    return {cnt == 0, wins > 1, 5'(cnt), ph, RLAT_BASE + 5'(ph >= st / 2)};
  endfunction
  task automatic run_cal(input logic [15:0] map, input logic s720);
    logic [16:0] e;
    sys_rst <= 1'b1;
    pass_map <= map;
    sweep_720 <= s720;
    ctl_cs_n <= 4'($urandom);
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int n = 0; n < 1000 && ctl_cal_success !== 1'b1 && ctl_cal_fail !== 1'b1; n++)
      @(posedge clk);
    #1;
    e = exp_cal(map, s720 ? 16 : 8);
    e_rlat = e[4:0];
    chk({ctl_cal_success, ctl_cal_fail}, {!(e[16] | e[15]), e[16] | e[15]});
    chk({rsu_no_dvw_err, rsu_grt_one_dvw_err}, e[16:15]);
    chk({mem_cs_n, ctl_reset_n, aux_scan_clk_reset_n}, {ctl_cs_n, 2'h3});
    if (!(e[16] | e[15]))
      chk({rsu_codvw_size, rsu_codvw_phase, resync_phase, ctl_rlat, ctl_wlat},
          {e[14:5], e[9:5], e[4:0], WLAT_DEFAULT});
  endtask
  task automatic rd_test(input logic [1:0] pat);
    int n;
    rd_word <= $urandom;
    next_en();
    ctl_doing_rd <= pat;
    ctl_cal_req <= 1'($urandom);
    next_en();
    ctl_doing_rd <= 2'h0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (ctl_rdata_valid !== 2'h0) break;
      next_en();
    end
    chk(n, e_rlat);
    chk({ctl_rdata_valid, ctl_rdata}, {pat, rd_word});
    next_en();
    #1;
    chk(ctl_rdata_valid, 2'h0);
  endtask
  task automatic dbg(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    dbg_cs <= 1'b1;
    dbg_wr <= wr;
    dbg_rd <= !wr;
    dbg_addr <= a;
    dbg_wr_data <= d;
    for (int n = 0; n < 10; n++) begin
      @(negedge clk);
      if (dbg_waitrequest === 1'b0) break;
    end
    @(posedge clk);
    rd_q = dbg_rd_data;
    dbg_cs <= 1'b0;
    dbg_wr <= 1'b0;
    dbg_rd <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    #1200000;
    fails++;
    print_verdict();
  end

  initial begin
    logic [35:0] w;
    logic [31:0] s;
    void'($urandom(49));
    {fails, n_compared} = '0;
    {sys_rst, global_reset_n} = 2'b10;
    {ctl_dqs_burst, ctl_wdata_valid, ctl_doing_rd, ctl_wdata, write_byte_mask} = '0;
    {ctl_mem_clk_disable, ctl_cal_req, sweep_720, pass_map, rd_word, wr_ok} = '0;
    {ctl_cs_n, ctl_cal_byte_lane_sel_n} = 6'h3F;
    {dll_code_local, dll_use_import, dqs_delay_ctrl_import} = '0;
    {dbg_cs, dbg_rd, dbg_wr, dbg_addr, dbg_wr_data} = '0;
    repeat (8) @(posedge clk);
    global_reset_n <= 1'b1;
    run_cal(16'h0000, 1'b0);
    run_cal(16'h0C03, 1'b1);
    for (int k = 0; k < 5; k++) begin
      if (k == 0) run_cal(16'h0060, 1'b0);
      else if (k == 1) run_cal(16'h00FF, 1'b0);
      else run_cal(16'(((1 << (1 + $urandom % 4)) - 1) << ($urandom % 12)), 1'b1);
      for (int p = 1; p < 4; p++) rd_test(2'(p));
    end
    // stall the pins until the buffer refuses, then drain in order
    next_en();
    ctl_cs_n <= 4'hE;
    ctl_dqs_burst <= 2'h3;
    repeat (ctl_wlat) next_en();
    #1;
    chk(mem_dqs_oe, 2'h3);
    for (int n = 0; n < 20; n++) begin
      w = {$urandom, 4'($urandom)};
      ctl_wdata <= w[35:4];
      write_byte_mask <= w[3:0];
      ctl_wdata_valid <= 2'h3;
      next_en();
      if (pre_rdy !== 1'b1) break;
      wq.push_back(w);
    end
    ctl_wdata_valid <= 2'h0;
    chk(wq.size(), FIFO_DEPTH);
    wr_ok <= 1'b1;
    for (int n = 0; n < 200 && wq.size() > 0; n++) begin
      next_en();
      #1;
      if (mem_dq_oe === 2'h3) chk({mem_dq_o, mem_dm_o, mem_dm_oe}, {wq.pop_front(), 2'h3});
    end
    chk(wq.size(), 0);
    ctl_dqs_burst <= 2'h0;
    for (int i = 0; i < 4; i++) begin
      ctl_mem_clk_disable <= 2'(i);
      dll_use_import <= i[0];
      dll_code_local <= 6'($urandom);
      dqs_delay_ctrl_import <= 6'($urandom);
      repeat (3) @(posedge clk);
      #1;
      chk({mem_clk_oe, mem_clk_n_o}, {~2'(i), ~mem_clk_o});
      chk({dqs_delay_ctrl_export, dqs_delay_ctrl},
          {dll_code_local, i[0] ? dqs_delay_ctrl_import : dll_code_local});
    end
    s = $urandom;
    dbg(1'b1, DBG_SCRATCH, s);
    dbg(1'b1, DBG_STATUS, 32'hFFFF_FFFF);
    dbg(1'b0, DBG_SCRATCH, 32'h0);
    chk(rd_q, s);
    dbg(1'b0, DBG_STATUS, 32'h0);
    chk(rd_q, 32'h0000_0001);
    dbg(1'b0, 3'h6, 32'h0);
    chk(rd_q, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
